// *** irq_consts.vh ***
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH
`define MISC_ADDR          8'h0c
`define CAN_CTRL_ADDR      8'h20
`define CAN_ID_ADDR        8'h23
`define SER_CTRL2_ADDR     8'h0f
`define SER_STATUS_ADDR    8'h10
`define TMR_CTRL_ADDR      8'h12
`define TMR_STATUS_ADDR    8'h13
`define WAKE_CTRL_ADDR     8'h30
`define PEND_ADDR          8'h31
`define MISC_RISING_BIT    6
`define MISC_FALLING_BIT   5
`define MISC_ENABLE_BIT    4
`define VEC_RESET          16'h3ffe
`define VEC_SWI            16'h3ffc
`define VEC_EXT            16'h3ffa
`define VEC_CAPTURE        16'h3ff8
`define VEC_COMPARE        16'h3ff6
`define VEC_OVERFLOW       16'h3ff4
`define VEC_SERIAL         16'h3ff2
`define VEC_CAN            16'h3ff0
`define SRC_NONE           3'd0
`define SRC_SWI            3'd1
`define SRC_EXT            3'd2
`define SRC_CAPTURE        3'd3
`define SRC_COMPARE        3'd4
`define SRC_OVERFLOW       3'd5
`define SRC_SERIAL         3'd6
`define SRC_CAN            3'd7
`endif

// *** sync2.v ***
`timescale 1ns/100ps
// two-flop synchroniser for pin levels
module sync2 #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         resetn_i,
  input  wire [W-1:0] async_i,
  input  wire [W-1:0] init_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] hold_reg;
  // both flops hold the level relative to its idle value, so reset leaves
  // every line at rest and no false edge follows release
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= {W{1'b0}};
      hold_reg <= {W{1'b0}};
    end else begin
      meta_reg <= async_i ^ init_i;
      hold_reg <= meta_reg;
    end
  end
  always @* begin
    sync_o = hold_reg ^ init_i;
  end
endmodule // sync2

// *** ext_sense.v ***
`timescale 1ns/100ps
// sensitivity selection and pending latch of the combined external request
module ext_sense (
  input  wire       clk_i,
  input  wire       resetn_i,
  input  wire       combined_ext_request_i,
  input  wire       ext_request_enable_i,
  input  wire       rising_sense_select_i,
  input  wire       falling_sense_select_i,
  input  wire       option_change_i,
  input  wire       ack_i,
  output wire       request_o,
  output wire       pending_o
);
  reg  prev_reg;
  reg  latch_reg;
  wire rise;
  wire fall;
  wire edge_hit;
  wire level_mode;
  // combined request is active high, so a falling edge of the request pin is a rise here
  assign rise       = combined_ext_request_i & ~prev_reg;
  assign fall       = ~combined_ext_request_i & prev_reg;
  assign level_mode = ~rising_sense_select_i & ~falling_sense_select_i;
  assign edge_hit   = ({rising_sense_select_i, falling_sense_select_i} == 2'b10) ? fall :
                      ({rising_sense_select_i, falling_sense_select_i} == 2'b11) ? (rise | fall) :
                      rise; // [R23]
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_reg  <= 1'b0;
      latch_reg <= 1'b0;
    end else begin
      prev_reg <= combined_ext_request_i;
      if (option_change_i)
        latch_reg <= 1'b0; // [R6]
      else if (edge_hit)
        latch_reg <= 1'b1; // [R7]
      else if (ack_i)
        latch_reg <= 1'b0; // [R8]
    end
  end
  assign pending_o = latch_reg;
  // level request is also latched on its onset; it stands until served, not only while the pin is held
  assign request_o = ext_request_enable_i &
                     (latch_reg | (level_mode & combined_ext_request_i)); // [R8] [R3]
endmodule // ext_sense

// *** irq_wake_ctrl.v ***
// Local design decision: strobed register access.
`timescale 1ns/100ps
`include "irq_consts.vh"
// Operation
// [R1] combined request is OR of enabled wake inputs and inverted request pin
// [R2] a high wake input masks later edges on all other request sources
// [R3] enable bit set permits pin and wake inputs; clear blocks both
// [R4] enable bit writable only with CPU mask set; reset sets it
// [R5] option writes with CPU mask clear are ignored
// [R6] selecting a different option clears a pending external request
// [R7] edge sensed while disabled stays latched until enable set
// [R8] latch cleared at service start; low-level request never latched (level mode here latches its onset too)
// [R9] recognised when unmasked, enabled, sensed; vector 3ffa/3ffb
// [R10] enabled input-direction wake pins request when pulled high (in rising-edge mode the code requests when pulled low)
// [R11] reset clears the wired-or wake enable
// [R12] wake input request ends stop state
// [R13] can cause register at 0023, enables at 0020, wake always enabled
// [R14] can causes: receive, transmit, error, overrun, sleep wake
// [R15] can requests vector through 3ff0/3ff1
// [R16] timer flags in bits 7..3 of 0013 request when enabled
// [R17] timer control 0012 holds capture, compare, overflow enables
// [R18] serial flags in bits 7..3 of 0010 request, vector 3ff2/3ff3
// [R19] serial control two 000f holds four request enables
// [R20] reset fetches from 3ffe/3fff and sets CPU mask
// [R21] stop with can asleep turns oscillator off until wake source
// [R22] wait stops cpu clocks, timers run, exits on listed requests
// [R23] two sense bits select edge and level modes; reset clears them
// [R24] priority reset, swi, external, capture, compare, overflow, serial, can
module irq_wake_ctrl (
  input  wire        clk_i,
  input  wire        resetn_i,
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  input  wire        cpu_mask_i,
  input  wire        swi_i,
  input  wire        ack_i,
  input  wire        stop_i,
  input  wire        wait_i,
  input  wire        request_pin_n_i,
  input  wire [7:0]  port_wake_i,
  input  wire [7:0]  port_is_input_i,
  input  wire        dedicated_wake_pin_i,
  input  wire        wake_option_i,
  input  wire [4:0]  timer_flags_i,
  input  wire [4:0]  serial_flags_i,
  input  wire [4:0]  can_cause_i,
  input  wire        can_asleep_i,
  input  wire        reset_fetch_i,
  output reg         irq_o,
  output reg  [15:0] vector_o,
  output reg  [2:0]  source_o,
  output wire        set_cpu_mask_o,
  output wire        osc_on_o,
  output wire        cpu_clk_en_o,
  output wire        timer_clk_en_o
);
  localparam ST_RUN  = 2'd0;
  localparam ST_STOP = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg  [7:0]  misc_interrupt_control_reg;
  reg  [7:0]  timer_control_reg;
  reg  [7:0]  serial_control_two_reg;
  reg  [7:0]  can_ctrl_reg;
  reg  [7:0]  can_id_reg;
  reg  [7:0]  wake_ctrl_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [7:0]  rdata_next;
  wire [7:0]  port_s;
  wire        req_pin_s;
  wire        dwake_s;
  wire [4:0]  tflag_s;
  wire [4:0]  sflag_s;
  wire [4:0]  cflag_s;
  wire [8:0]  wake_in;
  wire [8:0]  wake_en;
  wire [8:0]  wake_live;
  reg         wake_hold_reg;
  reg         pin_hold_reg;
  wire        wired_or_wake_enable;
  wire        combined_ext_request;
  wire        any_wake;
  wire        ext_req;
  wire        ext_pending;
  wire        opt_write;
  wire        opt_change;
  wire        cap_req;
  wire        cmp_req;
  wire        ovf_req;
  wire        ser_req;
  wire        can_req;
  wire        ack_ext;
  wire        wake_polarity;

  function [1:0] sense_bits;
    input [7:0] v;
    begin
      sense_bits = {v[`MISC_RISING_BIT], v[`MISC_FALLING_BIT]};
    end
  endfunction

  // every pin and peripheral flag is treated as asynchronous
  sync2 #(.W(25)) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .async_i  ({request_pin_n_i, dedicated_wake_pin_i, port_wake_i,
                timer_flags_i, serial_flags_i, can_cause_i}),
    .init_i   (25'h1000000),
    .sync_o   ({req_pin_s, dwake_s, port_s, tflag_s, sflag_s, cflag_s})
  );

  assign wired_or_wake_enable = wake_ctrl_reg[0];
  assign wake_in  = {dwake_s, port_s};
  assign wake_en  = {wake_ctrl_reg[1], wake_ctrl_reg[0] ? port_is_input_i : 8'h00};
  // wake polarity is opposite to the pin except in rising-edge mode; in both-edge mode the edge logic covers it
  assign wake_polarity = sense_bits(misc_interrupt_control_reg) == 2'b10;

  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : g_wake
      assign wake_live[g] = wake_en[g] & wired_or_wake_enable & wake_option_i &
                            (wake_in[g] ^ wake_polarity); // [R10]
    end
  endgenerate

  assign any_wake = |wake_live;

  // a held wake input forces the combined request high, masking the other sources
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_hold_reg <= 1'b0;
      pin_hold_reg  <= 1'b0;
    end else begin
      wake_hold_reg <= any_wake;
      if (!any_wake)
        pin_hold_reg <= ~req_pin_s;
    end
  end

  assign combined_ext_request = any_wake ? (wake_hold_reg ? 1'b1 : (1'b1 | pin_hold_reg))
                                         : ~req_pin_s; // [R1] [R2]

  assign opt_write  = wr_i && (addr_i == `MISC_ADDR) && cpu_mask_i; // [R4] [R5]
  assign opt_change = opt_write &&
                      (sense_bits(wdata_i) != sense_bits(misc_interrupt_control_reg)); // [R6]
  assign ack_ext    = ack_i && (source_o == `SRC_EXT);

  ext_sense u_ext (
    .clk_i                  (clk_i),
    .resetn_i               (resetn_i),
    .combined_ext_request_i (combined_ext_request),
    .ext_request_enable_i   (misc_interrupt_control_reg[`MISC_ENABLE_BIT]),
    .rising_sense_select_i  (misc_interrupt_control_reg[`MISC_RISING_BIT]),
    .falling_sense_select_i (misc_interrupt_control_reg[`MISC_FALLING_BIT]),
    .option_change_i        (opt_change),
    .ack_i                  (ack_ext),
    .request_o              (ext_req),
    .pending_o              (ext_pending)
  );

  assign cap_req = |(tflag_s[4:3] & {2{timer_control_reg[7]}}); // [R16] [R17]
  assign cmp_req = |(tflag_s[2:1] & {2{timer_control_reg[6]}}); // [R16] [R17]
  assign ovf_req = tflag_s[0] & timer_control_reg[5]; // [R16] [R17]
  // serial flags: tx empty, tx complete, overrun, rx full, idle
  assign ser_req = (sflag_s[4] & serial_control_two_reg[7]) |
                   (sflag_s[3] & serial_control_two_reg[6]) |
                   ((sflag_s[2] | sflag_s[1]) & serial_control_two_reg[5]) |
                   (sflag_s[0] & serial_control_two_reg[4]); // [R18] [R19]
  // causes: wake(4, unmaskable), overrun, error, transmit, receive
  assign can_req = cflag_s[4] | |(cflag_s[3:0] & can_ctrl_reg[3:0]); // [R13] [R14]

  // registers
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      misc_interrupt_control_reg <= 8'h10; // [R4] [R23]
      timer_control_reg          <= 8'h00;
      serial_control_two_reg     <= 8'h00;
      can_ctrl_reg               <= 8'h00;
      can_id_reg                 <= 8'h00;
      wake_ctrl_reg              <= 8'h00; // [R11]
    end else begin
      can_id_reg <= {3'h0, cflag_s}; // [R13]
      if (opt_write)
        misc_interrupt_control_reg <= {1'b0, wdata_i[6:4], 4'h0}; // [R4] [R5]
      if (wr_i && addr_i == `TMR_CTRL_ADDR)
        timer_control_reg <= {wdata_i[7:5], 5'h00};
      if (wr_i && addr_i == `SER_CTRL2_ADDR)
        serial_control_two_reg <= {wdata_i[7:4], 4'h0};
      if (wr_i && addr_i == `CAN_CTRL_ADDR)
        can_ctrl_reg <= {4'h0, wdata_i[3:0]};
      if (wr_i && addr_i == `WAKE_CTRL_ADDR)
        wake_ctrl_reg <= {6'h00, wdata_i[1:0]};
    end
  end

  always @* begin
    case (addr_i)
      `MISC_ADDR:       rdata_next = misc_interrupt_control_reg;
      `TMR_CTRL_ADDR:   rdata_next = timer_control_reg;
      `TMR_STATUS_ADDR: rdata_next = {tflag_s, 3'h0};
      `SER_CTRL2_ADDR:  rdata_next = serial_control_two_reg;
      `SER_STATUS_ADDR: rdata_next = {sflag_s, 3'h0};
      `CAN_CTRL_ADDR:   rdata_next = can_ctrl_reg;
      `CAN_ID_ADDR:     rdata_next = can_id_reg;
      `WAKE_CTRL_ADDR:  rdata_next = wake_ctrl_reg;
      `PEND_ADDR:       rdata_next = {5'h00, state_reg, ext_pending};
      default:          rdata_next = 8'h00;
    endcase
  end

  // priority encoder and vector
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o  <= 8'h00;
      irq_o    <= 1'b0;
      source_o <= `SRC_NONE;
      vector_o <= `VEC_RESET; // [R20]
    end else begin
      rdata_o <= rd_i ? rdata_next : 8'h00;
      irq_o   <= 1'b1;
      if (reset_fetch_i) begin
        irq_o <= 1'b0;
        source_o <= `SRC_NONE;
        vector_o <= `VEC_RESET; // [R20]
      end else if (swi_i) begin
        source_o <= `SRC_SWI;
        vector_o <= `VEC_SWI; // [R24]
      end else if (cpu_mask_i) begin
        irq_o <= 1'b0;
        source_o <= `SRC_NONE;
      end else if (ext_req) begin
        source_o <= `SRC_EXT;
        vector_o <= `VEC_EXT; // [R9] [R24]
      end else if (cap_req) begin
        source_o <= `SRC_CAPTURE;
        vector_o <= `VEC_CAPTURE; // [R16]
      end else if (cmp_req) begin
        source_o <= `SRC_COMPARE;
        vector_o <= `VEC_COMPARE; // [R16]
      end else if (ovf_req) begin
        source_o <= `SRC_OVERFLOW;
        vector_o <= `VEC_OVERFLOW; // [R16]
      end else if (ser_req) begin
        source_o <= `SRC_SERIAL;
        vector_o <= `VEC_SERIAL; // [R18]
      end else if (can_req) begin
        source_o <= `SRC_CAN;
        vector_o <= `VEC_CAN; // [R15]
      end else begin
        irq_o <= 1'b0;
        source_o <= `SRC_NONE;
      end
    end
  end

  // cpu sets its mask on reset and when it takes a request
  assign set_cpu_mask_o = reset_fetch_i | ack_i; // [R9] [R20]

  // low-power states; wake ignores the cpu mask so a masked request still resumes
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (stop_i && can_asleep_i)
          state_next = ST_STOP; // [R21]
        else if (wait_i)
          state_next = ST_WAIT;
      end
      ST_STOP: begin
        if (ext_req || any_wake || can_req)
          state_next = ST_RUN; // [R12] [R21]
      end
      ST_WAIT: begin
        if (ext_req || cap_req || cmp_req || ovf_req || ser_req)
          state_next = ST_RUN; // [R22]
      end
      default: state_next = ST_RUN;
    endcase
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // the clock stays running here; stop gates the oscillator, cpu and timer enable outputs
  assign osc_on_o       = state_reg != ST_STOP; // [R21]
  assign cpu_clk_en_o   = state_reg == ST_RUN; // [R22]
  assign timer_clk_en_o = state_reg != ST_STOP; // [R22]
endmodule // irq_wake_ctrl

// *** cpu_model.sv ***
`timescale 1ns/100ps
// cpu side: interrupt mask, reset fetch and service start
module cpu_model (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic irq_i,
  input  wire logic set_mask_i,
  input  wire logic imask_i,
  input  wire logic svc_i,
  output logic      mask_o,
  output logic      ack_o,
  output logic      fetch_o
);
  logic [1:0] fetch_cnt;

  // fetch stands a few cycles after reset, as a real vector fetch would
  assign fetch_o = fetch_cnt != 2'h0;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_o    <= 1'b1;
      ack_o     <= 1'b0;
      fetch_cnt <= 2'h3;
    end else begin
      if (fetch_cnt != 2'h0) begin
        fetch_cnt <= fetch_cnt - 2'h1;
      end
      ack_o  <= svc_i && irq_i;
      mask_o <= set_mask_i || imask_i;
    end
  end
endmodule // cpu_model

// *** irq_wake_ctrl_assertions.sv ***
`timescale 1ns/100ps
`include "irq_consts.vh"
module irq_wake_ctrl_checker (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        cpu_mask_i,
  input wire logic        swi_i,
  input wire logic        ack_i,
  input wire logic        stop_i,
  input wire logic        wait_i,
  input wire logic        can_asleep_i,
  input wire logic        reset_fetch_i,
  input wire logic        irq_o,
  input wire logic [15:0] vector_o,
  input wire logic [2:0]  source_o,
  input wire logic        set_cpu_mask_o,
  input wire logic        osc_on_o,
  input wire logic        cpu_clk_en_o,
  input wire logic        timer_clk_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  vector_map_a: assert property (
    irq_o |-> vector_o == 16'h3ffe - {12'h000, source_o, 1'b0})
    else $error("vector does not match source");
  mask_set_a: assert property (
    ack_i || reset_fetch_i |-> set_cpu_mask_o)
    else $error("cpu mask not set");
  masked_quiet_a: assert property (
    $past(cpu_mask_i) && $past(cpu_mask_i, 2) && !$past(swi_i) && !swi_i |-> !irq_o)
    else $error("request while masked");
  swi_first_a: assert property (
    swi_i [*4] |-> irq_o && source_o == `SRC_SWI)
    else $error("software request not first");
  osc_stop_a: assert property (
    !osc_on_o |-> !cpu_clk_en_o && !timer_clk_en_o)
    else $error("clocks run with oscillator off");
  osc_gate_a: assert property (
    $fell(osc_on_o) |-> $past(stop_i) && $past(can_asleep_i))
    else $error("oscillator off without stop");
  wait_gate_a: assert property (
    $fell(cpu_clk_en_o) |-> $past(stop_i) || $past(wait_i))
    else $error("cpu clock stopped without cause");
  timer_run_a: assert property (
    osc_on_o && !cpu_clk_en_o |-> timer_clk_en_o)
    else $error("timer clock stopped in wait");
endmodule // irq_wake_ctrl_checker

// *** irq_wake_ctrl_tb.sv ***
`timescale 1ns/100ps
`include "irq_consts.vh"
module irq_wake_ctrl_tb;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        swi_i = 1'b0;
  logic        stop_i = 1'b0;
  logic        wait_i = 1'b0;
  logic        request_pin_n_i = 1'b1;
  logic [7:0]  port_wake_i = 8'h00;
  logic [7:0]  port_is_input_i = 8'hff;
  logic        dedicated_wake_pin_i = 1'b0;
  logic        wake_option_i = 1'b1;
  logic [4:0]  timer_flags_i = 5'h00;
  logic [4:0]  serial_flags_i = 5'h00;
  logic [4:0]  can_cause_i = 5'h00;
  logic        can_asleep_i = 1'b0;
  logic        imask = 1'b1;
  logic        svc = 1'b0;
  wire  [7:0]  rdata_o;
  wire  [15:0] vector_o;
  wire  [2:0]  source_o;
  wire         cpu_mask_i, ack_i, reset_fetch_i, irq_o, set_cpu_mask_o;
  wire         osc_on_o, cpu_clk_en_o, timer_clk_en_o;
  int          errors = 0;
  int          num_checks = 0;
  int          i;

  always #50 clk_i = ~clk_i;

  irq_wake_ctrl dut (.clk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .cpu_mask_i, .swi_i, .ack_i, .stop_i, .wait_i, .request_pin_n_i, .port_wake_i,
    .port_is_input_i, .dedicated_wake_pin_i, .wake_option_i, .timer_flags_i,
    .serial_flags_i, .can_cause_i, .can_asleep_i, .reset_fetch_i, .irq_o, .vector_o,
    .source_o, .set_cpu_mask_o, .osc_on_o, .cpu_clk_en_o, .timer_clk_en_o);

  cpu_model cpu (.clk_i, .resetn_i, .irq_i(irq_o), .set_mask_i(set_cpu_mask_o),
    .imask_i(imask), .svc_i(svc), .mask_o(cpu_mask_i), .ack_o(ack_i),
    .fetch_o(reset_fetch_i));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clk_i);
  endtask

  // two synchroniser flops, the pending latch and the output register, with one cycle spare
  task automatic see(input logic [2:0] s);
    repeat (5) @(posedge clk_i);
    #1 chk(irq_o, s != 3'd0);
    chk(source_o, s);
    if (s != 3'd0) chk(vector_o, 16'h3ffe - {s, 1'b0});
    @(posedge clk_i);
  endtask

  task automatic im(input logic v);
    imask <= v;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic serve;
    svc <= 1'b1;
    @(posedge clk_i);
    svc <= 1'b0;
  endtask

  task automatic pin_pulse;
    request_pin_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    request_pin_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic op(input logic s);
    if (s) stop_i <= 1'b1;
    else wait_i <= 1'b1;
    @(posedge clk_i);
    stop_i <= 1'b0;
    wait_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    errors++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(vector_o, 16'h3ffe);
    rd(`MISC_ADDR, 8'h10);
    rd(`WAKE_CTRL_ADDR, 8'h00);
    rd(8'h01, 8'h00);
    im(1'b0);
    wr(`MISC_ADDR, 8'h60);
    rd(`MISC_ADDR, 8'h10);
    im(1'b1);
    wr(`MISC_ADDR, 8'h60);
    rd(`MISC_ADDR, 8'h60);
    wr(`MISC_ADDR, 8'h10);
    im(1'b0);
    timer_flags_i <= 5'h1f;
    see(3'd0);
    wr(`TMR_CTRL_ADDR, 8'h20);
    see(3'd5);
    wr(`TMR_CTRL_ADDR, 8'he0);
    see(3'd3);
    swi_i <= 1'b1;
    see(3'd1);
    swi_i <= 1'b0;
    timer_flags_i <= 5'h00;
    see(3'd0);
    for (i = 0; i < 5; i++) begin
      timer_flags_i <= 5'h10 >> i;
      see(i < 2 ? 3'd3 : (i < 4 ? 3'd4 : 3'd5));
      timer_flags_i <= 5'h00;
      see(3'd0);
    end
    op(1'b0);
    chk(cpu_clk_en_o, 1'b0);
    chk(timer_clk_en_o, 1'b1);
    @(posedge clk_i);
    timer_flags_i <= 5'h01;
    see(3'd5);
    #1 chk(cpu_clk_en_o, 1'b1);
    @(posedge clk_i);
    timer_flags_i <= 5'h00;
    wr(`SER_CTRL2_ADDR, 8'h10);
    serial_flags_i <= 5'h04;
    see(3'd0);
    serial_flags_i <= 5'h01;
    see(3'd6);
    wr(`SER_CTRL2_ADDR, 8'hf0);
    wr(`CAN_CTRL_ADDR, 8'h0f);
    for (i = 0; i < 5; i++) begin
      serial_flags_i <= 5'h01 << i;
      see(3'd6);
      serial_flags_i <= 5'h00;
      can_cause_i <= 5'h01 << i;
      see(3'd7);
      can_cause_i <= 5'h00;
      see(3'd0);
    end
    wr(`CAN_CTRL_ADDR, 8'h00);
    can_cause_i <= 5'h01;
    see(3'd0);
    can_cause_i <= 5'h10;
    see(3'd7);
    can_cause_i <= 5'h00;
    request_pin_n_i <= 1'b0;
    see(3'd2);
    serve();
    request_pin_n_i <= 1'b1;
    see(3'd0);
    im(1'b1);
    wr(`MISC_ADDR, 8'h20);
    pin_pulse();
    im(1'b0);
    see(3'd0);
    im(1'b1);
    wr(`MISC_ADDR, 8'h30);
    im(1'b0);
    see(3'd2);
    serve();
    see(3'd0);
    im(1'b1);
    wr(`MISC_ADDR, 8'h20);
    pin_pulse();
    wr(`MISC_ADDR, 8'h40);
    wr(`MISC_ADDR, 8'h50);
    im(1'b0);
    see(3'd0);
    im(1'b1);
    wr(`MISC_ADDR, 8'h10);
    wr(`WAKE_CTRL_ADDR, 8'h03);
    im(1'b0);
    port_is_input_i <= 8'hf7;
    port_wake_i <= 8'h08;
    see(3'd0);
    port_is_input_i <= 8'hff;
    see(3'd2);
    serve();
    port_wake_i <= 8'h00;
    dedicated_wake_pin_i <= 1'b1;
    see(3'd2);
    serve();
    dedicated_wake_pin_i <= 1'b0;
    see(3'd0);
    can_asleep_i <= 1'b1;
    op(1'b1);
    chk(osc_on_o, 1'b0);
    @(posedge clk_i);
    port_wake_i <= 8'h08;
    see(3'd2);
    #1 chk(osc_on_o, 1'b1);
    @(posedge clk_i);
    serve();
    // wake held high in falling-edge mode: a pin pulse must not raise a new edge
    im(1'b1);
    wr(`MISC_ADDR, 8'h30);
    im(1'b0);
    see(3'd0);
    pin_pulse();
    see(3'd0);
    port_wake_i <= 8'h00;
    summarize();
  end
endmodule // irq_wake_ctrl_tb

bind irq_wake_ctrl irq_wake_ctrl_checker chk_u (.clk_i, .resetn_i, .cpu_mask_i, .swi_i,
  .ack_i, .stop_i, .wait_i, .can_asleep_i, .reset_fetch_i, .irq_o, .vector_o, .source_o,
  .set_cpu_mask_o, .osc_on_o, .cpu_clk_en_o, .timer_clk_en_o);
